//--- design/beacon_sched_pkg.sv
// shared constants, register map and carrier types of the frame and beacon scheduler
package beacon_sched_pkg;
  localparam int CNT_W   = 16;
  localparam int SEQ_W   = 5;
  localparam int SLOT_W  = 3;
  localparam int FRQ_W   = 4;
  localparam int ADDR_W  = 3;
  localparam int DATA_W  = 32;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CTRL_OFS      = 3'h0;
  localparam logic [ADDR_W-1:0] FRAME_LEN_OFS = 3'h1;
  localparam logic [ADDR_W-1:0] BCN_LEN_OFS   = 3'h2;
  localparam logic [ADDR_W-1:0] MIN_SCP_OFS   = 3'h3;
  localparam logic [ADDR_W-1:0] SLOT_PLAN_OFS = 3'h4;
  localparam logic [ADDR_W-1:0] STATUS_OFS    = 3'h5;
  localparam logic [ADDR_W-1:0] RELAYS_OFS    = 3'h6;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_ROOT_BIT  = 0;
  localparam int CTRL_EN_BIT    = 1;
  localparam int PLAN_TGT_LSB   = 8;
  localparam logic [CNT_W-1:0]  RST_FRAME_LEN = 16'h0114;
  localparam logic [CNT_W-1:0]  RST_BCN_LEN   = 16'h0004;
  localparam logic [CNT_W-1:0]  RST_MIN_SCP   = 16'h0040;
  localparam logic [SLOT_W-1:0] MAX_SLOTS     = 3'h7;
  localparam logic [FRQ_W-1:0]  ROOT_FREQ     = 4'h1;
  localparam logic [SEQ_W-1:0]  LEAD_FRAMES   = 5'h02;

  typedef enum logic [2:0] {
    PKT_NONE      = 3'b000,
    PKT_PROMO_ACK = 3'b001,
    PKT_SLOT_ASG  = 3'b010,
    PKT_SLOT_ACK  = 3'b011,
    PKT_FRM_CHG   = 3'b100
  } pkt_kind_type;

  typedef struct packed {
    pkt_kind_type      kind;
    logic              for_me;
    logic              dest_below;
    logic [SLOT_W-1:0] slot_index;
    logic [SEQ_W-1:0]  sequence_no;
    logic [FRQ_W-1:0]  frequency;
    logic [SEQ_W-1:0]  target_seq;
    logic [SLOT_W-1:0] slot_count;
  } pkt_type;

  typedef struct packed {
    logic [SEQ_W-1:0]  sequence_no;
    logic [SLOT_W-1:0] slot_count;
    logic [SLOT_W-1:0] slot_index;
    logic [CNT_W-1:0]  scp_len;
    logic [CNT_W-1:0]  cfp_len;
    logic              robust_mode;
    logic              max_power;
  } beacon_type;
endpackage : beacon_sched_pkg

//--- design/beacon_sched.sv
// frame timing, beacon scheduling and beacon-slot control packet handling
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ns
module beacon_sched
  import beacon_sched_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic              sym_tick,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [DATA_W-1:0] rd_data,
  input  wire logic              rx_valid,
  input  wire pkt_type           rx_pkt,
  input  wire logic              rx_bcn_valid,
  input  wire beacon_type        rx_bcn,
  input  wire logic              cfp_req,
  input  wire logic [CNT_W-1:0]  cfp_req_len,
  output logic                   cfp_grant,
  output logic                   cfp_refuse,
  output logic                   tx_valid,
  output pkt_type                tx_pkt,
  output logic                   bcn_valid,
  output beacon_type             bcn,
  output logic                   bcn_slot_active,
  output logic                   scp_active,
  output logic                   cfp_active
);
  typedef struct packed {
    logic              root;
    logic              en;
    logic [CNT_W-1:0]  frame_len;
    logic [CNT_W-1:0]  bcn_len;
    logic [CNT_W-1:0]  min_scp;
    logic [CNT_W-1:0]  cnt;
    logic [SEQ_W-1:0]  seq;
    logic [SLOT_W-1:0] slots;
    logic [CNT_W-1:0]  cfp_len;
    logic [SLOT_W-1:0] own_slot;
    logic [FRQ_W-1:0]  own_freq;
    logic [FRQ_W-1:0]  frame_div;
    logic              pend;
    logic [SLOT_W-1:0] pend_slots;
    logic [SEQ_W-1:0]  pend_tgt;
    logic              own_pend;
    logic [SLOT_W-1:0] own_pend_slot;
    logic [FRQ_W-1:0]  own_pend_freq;
    logic [SEQ_W-1:0]  own_pend_tgt;
    logic              cfp_pend;
    logic [CNT_W-1:0]  cfp_pend_len;
    logic [SLOT_W-1:0] relays;
    logic              fc_owed;
    logic              ack_seen;
    logic [DATA_W-1:0] rd_data;
    logic              cfp_grant;
    logic              cfp_refuse;
    logic              tx_valid;
    pkt_type           tx_pkt;
    logic              bcn_valid;
    beacon_type        bcn;
    logic              bcn_slot_active;
    logic              scp_active;
    logic              cfp_active;
  } state_type;

  state_type st_r;
  state_type st_nxt;

  logic [CNT_W-1:0]  bcn_end;
  logic [CNT_W-1:0]  cfp_eff;
  logic [CNT_W-1:0]  cfp_start;
  logic [CNT_W-1:0]  scp_len;
  logic              frame_end;
  logic [SEQ_W-1:0]  seq_inc;
  logic [SLOT_W-1:0] plan_slots;

  // ----------------------------------------------------------------
  // frame geometry
  // ----------------------------------------------------------------
  always_comb begin
    bcn_end   = CNT_W'(st_r.bcn_len * CNT_W'(st_r.slots));
    // a grant that would squeeze the shared period is dropped, not honoured
    if (CNT_W'(bcn_end + st_r.cfp_len + st_r.min_scp) <= st_r.frame_len) begin
      cfp_eff = st_r.cfp_len;
    end else begin
      cfp_eff = '0;
    end
    cfp_start = CNT_W'(st_r.frame_len - cfp_eff);
    scp_len   = CNT_W'(cfp_start - bcn_end);
    frame_end = sym_tick && (st_r.cnt == CNT_W'(st_r.frame_len - 16'h0001));
    seq_inc   = SEQ_W'(st_r.seq + 5'h01);
  end

  always_comb begin
    st_nxt = st_r;
    plan_slots = '0;
    st_nxt.tx_valid   = 1'b0;
    st_nxt.bcn_valid  = 1'b0;
    st_nxt.cfp_grant  = 1'b0;
    st_nxt.cfp_refuse = 1'b0;
    st_nxt.rd_data    = '0;

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    if (wr_en) begin
      if (addr == CTRL_OFS) begin
        st_nxt.root = wr_data[CTRL_ROOT_BIT];
        st_nxt.en   = wr_data[CTRL_EN_BIT];
      end else if (addr == FRAME_LEN_OFS) begin
        st_nxt.frame_len = wr_data[CNT_W-1:0];
      end else if (addr == BCN_LEN_OFS) begin
        st_nxt.bcn_len = wr_data[CNT_W-1:0];
      end else if (addr == MIN_SCP_OFS) begin
        st_nxt.min_scp = wr_data[CNT_W-1:0];
      end else if (addr == SLOT_PLAN_OFS) begin
        plan_slots = wr_data[SLOT_W-1:0];
        // never one slot, or fewer than relays plus root, while relays exist
        if (plan_slots == '0 || (st_r.relays != '0 && plan_slots <= st_r.relays)) begin
          plan_slots = (st_r.relays == '0) ? 3'h1 : SLOT_W'(st_r.relays + 3'h1);
        end
        st_nxt.pend       = 1'b1;
        st_nxt.pend_slots = plan_slots;
        st_nxt.pend_tgt   = wr_data[PLAN_TGT_LSB +: SEQ_W];
        st_nxt.fc_owed    = st_r.root && (plan_slots != st_r.slots);
      end
    end
    if (rd_en) begin
      if (addr == CTRL_OFS) begin
        st_nxt.rd_data = DATA_W'({st_r.en, st_r.root});
      end else if (addr == FRAME_LEN_OFS) begin
        st_nxt.rd_data = DATA_W'(st_r.frame_len);
      end else if (addr == BCN_LEN_OFS) begin
        st_nxt.rd_data = DATA_W'(st_r.bcn_len);
      end else if (addr == MIN_SCP_OFS) begin
        st_nxt.rd_data = DATA_W'(st_r.min_scp);
      end else if (addr == SLOT_PLAN_OFS) begin
        st_nxt.rd_data = DATA_W'({st_r.pend_tgt, 5'h00, st_r.pend_slots});
      end else if (addr == STATUS_OFS) begin
        // top counter bit is dropped so the status fits one word
        st_nxt.rd_data = {st_r.cnt[CNT_W-2:0], st_r.ack_seen, st_r.pend, st_r.seq, st_r.own_slot,
                          st_r.own_freq, st_r.slots};
      end else if (addr == RELAYS_OFS) begin
        st_nxt.rd_data = DATA_W'(st_r.relays);
      end else begin
        st_nxt.rd_data = '0;
      end
    end

    // ----------------------------------------------------------------
    // received packets
    // ----------------------------------------------------------------
    if (rx_valid && st_r.en) begin
      if (st_r.root && rx_pkt.kind == PKT_PROMO_ACK && st_r.relays != MAX_SLOTS - 3'h1) begin
        // parent is the root, which beacons every frame; a larger frequency
        // keeps the new relay off a beacon right after every root beacon
        st_nxt.relays             = SLOT_W'(st_r.relays + 3'h1);
        st_nxt.tx_valid           = 1'b1;
        st_nxt.tx_pkt             = '0;
        st_nxt.tx_pkt.kind        = PKT_SLOT_ASG;
        st_nxt.tx_pkt.dest_below  = 1'b1;
        st_nxt.tx_pkt.slot_index  = SLOT_W'(st_r.relays + 3'h1);
        st_nxt.tx_pkt.sequence_no = st_r.seq;
        st_nxt.tx_pkt.frequency   = FRQ_W'(ROOT_FREQ + 4'h1);
        st_nxt.tx_pkt.target_seq  = SEQ_W'(st_r.seq + LEAD_FRAMES);
        st_nxt.tx_pkt.slot_count  = SLOT_W'(st_r.relays + 3'h2);
        st_nxt.pend               = 1'b1;
        st_nxt.pend_slots         = SLOT_W'(st_r.relays + 3'h2);
        st_nxt.pend_tgt           = SEQ_W'(st_r.seq + LEAD_FRAMES);
        st_nxt.fc_owed            = 1'b1;
      end else if (st_r.root && rx_pkt.kind == PKT_SLOT_ACK) begin
        st_nxt.ack_seen = 1'b1;
      end else if (!st_r.root && rx_pkt.kind == PKT_SLOT_ASG) begin
        if (rx_pkt.for_me) begin
          st_nxt.own_pend      = 1'b1;
          st_nxt.own_pend_slot = rx_pkt.slot_index;
          st_nxt.own_pend_freq = rx_pkt.frequency;
          st_nxt.own_pend_tgt  = rx_pkt.target_seq;
          st_nxt.tx_valid      = 1'b1;
          st_nxt.tx_pkt        = rx_pkt;
          st_nxt.tx_pkt.kind   = PKT_SLOT_ACK;
          st_nxt.tx_pkt.for_me = 1'b0;
        end else if (rx_pkt.dest_below) begin
          st_nxt.tx_valid = 1'b1;
          st_nxt.tx_pkt   = rx_pkt;
        end
      end else if (!st_r.root && rx_pkt.kind == PKT_FRM_CHG) begin
        st_nxt.pend       = 1'b1;
        st_nxt.pend_slots = rx_pkt.slot_count;
        st_nxt.pend_tgt   = rx_pkt.target_seq;
        st_nxt.tx_valid   = 1'b1;
        st_nxt.tx_pkt     = rx_pkt;
      end
    end
    // frame change goes out once the slot assignment has left
    if (st_r.fc_owed && !st_nxt.tx_valid) begin
      // a plan written in this very cycle keeps its own broadcast owed
      st_nxt.fc_owed           = st_nxt.fc_owed && wr_en && addr == SLOT_PLAN_OFS;
      st_nxt.tx_valid          = 1'b1;
      st_nxt.tx_pkt            = '0;
      st_nxt.tx_pkt.kind       = PKT_FRM_CHG;
      st_nxt.tx_pkt.slot_count = st_r.pend_slots;
      st_nxt.tx_pkt.target_seq = st_r.pend_tgt;
      st_nxt.tx_pkt.sequence_no = st_r.seq;
    end

    // ----------------------------------------------------------------
    // contention-free requests
    // ----------------------------------------------------------------
    if (cfp_req && st_r.root && st_r.en) begin
      // only one contention-free period until reset, since cfp_len is never cleared, and only if the shared one keeps its floor
      if (!st_r.cfp_pend && st_r.cfp_len == '0
          && CNT_W'(bcn_end + cfp_req_len + st_r.min_scp) <= st_r.frame_len) begin
        st_nxt.cfp_grant    = 1'b1;
        st_nxt.cfp_pend     = 1'b1;
        st_nxt.cfp_pend_len = cfp_req_len;
      end else begin
        st_nxt.cfp_refuse = 1'b1;
      end
    end

    // ----------------------------------------------------------------
    // symbol counter, superframe and beacon emission
    // ----------------------------------------------------------------
    if (st_r.en && sym_tick) begin
      if (frame_end) begin
        st_nxt.cnt = '0;
        st_nxt.seq = seq_inc;
        st_nxt.frame_div = (st_r.frame_div == '0) ? FRQ_W'(st_r.own_freq - 4'h1)
                                                  : FRQ_W'(st_r.frame_div - 4'h1);
        if (st_r.pend && seq_inc == st_r.pend_tgt) begin
          st_nxt.pend  = 1'b0;
          st_nxt.slots = st_r.pend_slots;
        end
        if (st_r.own_pend && seq_inc == st_r.own_pend_tgt) begin
          st_nxt.own_pend  = 1'b0;
          st_nxt.own_slot  = st_r.own_pend_slot;
          st_nxt.own_freq  = st_r.own_pend_freq;
          st_nxt.frame_div = '0;
        end
        if (st_r.cfp_pend) begin
          st_nxt.cfp_pend = 1'b0;
          st_nxt.cfp_len  = st_r.cfp_pend_len;
        end
      end else begin
        st_nxt.cnt = CNT_W'(st_r.cnt + 16'h0001);
      end
      if ((st_r.root && st_r.cnt == '0)
          || (!st_r.root && st_r.own_slot != '0 && st_r.frame_div == '0
              && st_r.cnt == CNT_W'(st_r.bcn_len * CNT_W'(st_r.own_slot)))) begin
        st_nxt.bcn_valid       = 1'b1;
        st_nxt.bcn.sequence_no = st_r.seq;
        st_nxt.bcn.slot_count  = st_r.slots;
        st_nxt.bcn.slot_index  = st_r.root ? '0 : st_r.own_slot;
        st_nxt.bcn.scp_len     = scp_len;
        st_nxt.bcn.cfp_len     = cfp_eff;
        st_nxt.bcn.robust_mode = 1'b1;
        st_nxt.bcn.max_power   = 1'b1;
      end
    end
    // a heard beacon resyncs timing; without one the last structure stands
    if (rx_bcn_valid && !st_r.root && st_r.en) begin
      st_nxt.seq     = rx_bcn.sequence_no;
      st_nxt.slots   = rx_bcn.slot_count;
      st_nxt.cfp_len = rx_bcn.cfp_len;
      st_nxt.cnt     = CNT_W'(st_r.bcn_len * CNT_W'(rx_bcn.slot_index));
    end

    st_nxt.bcn_slot_active = st_r.en && st_r.cnt < bcn_end;
    st_nxt.scp_active      = st_r.en && st_r.cnt >= bcn_end && st_r.cnt < cfp_start;
    st_nxt.cfp_active      = st_r.en && cfp_eff != '0 && st_r.cnt >= cfp_start;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r           <= '0;
      st_r.frame_len <= RST_FRAME_LEN;
      st_r.bcn_len   <= RST_BCN_LEN;
      st_r.min_scp   <= RST_MIN_SCP;
      st_r.slots     <= 3'h1;
      st_r.own_freq  <= ROOT_FREQ;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign rd_data         = st_r.rd_data;
  assign cfp_grant       = st_r.cfp_grant;
  assign cfp_refuse      = st_r.cfp_refuse;
  assign tx_valid        = st_r.tx_valid;
  assign tx_pkt          = st_r.tx_pkt;
  assign bcn_valid       = st_r.bcn_valid;
  assign bcn             = st_r.bcn;
  assign bcn_slot_active = st_r.bcn_slot_active;
  assign scp_active      = st_r.scp_active;
  assign cfp_active      = st_r.cfp_active;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  seq_wrap_a: assert property (@(posedge core_clk) disable iff (rst)
    (ce && st_r.en && frame_end && !rx_bcn_valid) |=> st_r.seq == $past(seq_inc))
    else $error("sequence did not advance by one at frame end");
  root_beacon_a: assert property (@(posedge core_clk) disable iff (rst)
    (ce && st_r.en && st_r.root && sym_tick && st_r.cnt == '0) |=> bcn_valid && bcn.slot_index == '0)
    else $error("root beacon missing in slot zero");
  beacon_robust_a: assert property (@(posedge core_clk) disable iff (rst)
    bcn_valid |-> bcn.robust_mode && bcn.max_power)
    else $error("beacon not robust at full power");
  scp_floor_a: assert property (@(posedge core_clk) disable iff (rst)
    (bcn_valid && st_r.root) |-> bcn.scp_len >= st_r.min_scp || st_r.frame_len < CNT_W'(bcn_end + st_r.min_scp))
    else $error("shared period below minimum");
  min_slots_a: assert property (@(posedge core_clk) disable iff (rst)
    (st_r.root && st_r.relays != '0) |-> st_r.pend_slots >= 3'h2)
    else $error("slot plan drops to one with relays present");
  frame_change_a: assert property (@(posedge core_clk) disable iff (rst)
    (tx_valid && tx_pkt.kind == PKT_SLOT_ASG && st_r.root)
      |-> ##[1:8] (tx_valid && tx_pkt.kind == PKT_FRM_CHG))
    else $error("frame change packet did not follow promotion");
  apply_target_a: assert property (@(posedge core_clk) disable iff (rst)
    ($changed(st_r.slots) && !$past(rx_bcn_valid)) |-> st_r.seq == $past(st_r.pend_tgt))
    else $error("slot count changed outside target frame");
  forward_a: assert property (@(posedge core_clk) disable iff (rst)
    (ce && rx_valid && st_r.en && !st_r.root && rx_pkt.kind == PKT_SLOT_ASG
      && !rx_pkt.for_me && rx_pkt.dest_below) |=> tx_valid && tx_pkt == $past(rx_pkt))
    else $error("slot assignment not forwarded");
  period_split_a: assert property (@(posedge core_clk) disable iff (rst)
    !(scp_active && (bcn_slot_active || cfp_active)))
    else $error("shared period overlaps another period");
  relay_ack_a: assert property (@(posedge core_clk) disable iff (rst)
    (ce && rx_valid && st_r.en && !st_r.root && rx_pkt.kind == PKT_SLOT_ASG && rx_pkt.for_me)
      |=> tx_valid && tx_pkt.kind == PKT_SLOT_ACK)
    else $error("slot assignment not acknowledged");
  rebroadcast_a: assert property (@(posedge core_clk) disable iff (rst)
    (ce && rx_valid && st_r.en && !st_r.root && rx_pkt.kind == PKT_FRM_CHG)
      |=> tx_valid && tx_pkt == $past(rx_pkt))
    else $error("frame change not rebroadcast");
  grant_answer_a: assert property (@(posedge core_clk) disable iff (rst)
    (ce && cfp_req && st_r.root && st_r.en) |=> (cfp_grant ^ cfp_refuse))
    else $error("request neither granted nor refused exactly once");
  scp_start_a: assert property (@(posedge core_clk) disable iff (rst)
    (ce && st_r.en && st_r.cnt == bcn_end && bcn_end < cfp_start) |=> scp_active)
    else $error("shared period late after last beacon slot");
  scp_ceiling_a: assert property (@(posedge core_clk) disable iff (rst)
    (bcn_valid && st_r.root && (bcn.cfp_len != '0 || bcn.slot_count > 3'h1))
      |-> bcn.scp_len != CNT_W'(st_r.frame_len - st_r.bcn_len))
    else $error("maximum shared period with extra slots or free period");
endmodule : beacon_sched

//--- sim/relay_peer.sv
// behavioural peer node on the far side of the link packet interface
`timescale 1ns/1ns
module relay_peer
  import beacon_sched_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       ack_en,
  input  wire logic [3:0] ack_delay,
  input  wire logic       send,
  input  wire pkt_type    send_pkt,
  input  wire logic       tx_valid,
  input  wire pkt_type    tx_pkt,
  output logic            rx_valid,
  output pkt_type         rx_pkt
);
  pkt_type    ack_r;
  logic [4:0] wait_r;

  always_ff @(posedge core_clk) begin
    rx_valid <= 1'b0;
    // idle bus toggles so a stale packet is never mistaken for a new one
    rx_pkt <= pkt_type'(~rx_pkt);
    if (rst) begin
      wait_r <= 5'h00;
      rx_pkt <= '0;
    end else begin
      if (send) begin
        rx_valid <= 1'b1;
        rx_pkt   <= send_pkt;
      end else if (wait_r == 5'h01) begin
        rx_valid <= 1'b1;
        rx_pkt   <= ack_r;
      end
      if (wait_r != 5'h00) begin
        wait_r <= wait_r - 5'h01;
      end
      if (ack_en && tx_valid && tx_pkt.kind == PKT_SLOT_ASG) begin
        ack_r      <= tx_pkt;
        ack_r.kind <= PKT_SLOT_ACK;
        wait_r     <= {1'b0, ack_delay} + 5'h01;
      end
    end
  end
endmodule : relay_peer

//--- sim/beacon_sched_bench.sv
// self-checking bench for the frame and beacon scheduler
`timescale 1ns/1ns
module beacon_sched_bench;
  import beacon_sched_pkg::*;
  logic              core_clk = 1'b0, rst = 1'b1, ce = 1'b1, sym_tick = 1'b1;
  logic              wr_en = 1'b0, rd_en = 1'b0, cfp_req = 1'b0, send = 1'b0, ack_en = 1'b0;
  logic              rx_valid, rx_bcn_valid = 1'b0, cfp_grant, cfp_refuse, tx_valid;
  logic              bcn_valid, bcn_slot_active, scp_active, cfp_active;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wr_data = '0, rd_data, d;
  logic [CNT_W-1:0]  cfp_req_len = '0;
  pkt_type           rx_pkt, tx_pkt, send_pkt = '0;
  beacon_type        rx_bcn = '0, bcn;
  int                errors = 0, n_checks = 0, cyc = 0, bs, ss, cs;

  beacon_sched dut (.core_clk, .rst, .ce, .sym_tick, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
    .rx_valid, .rx_pkt, .rx_bcn_valid, .rx_bcn, .cfp_req, .cfp_req_len, .cfp_grant, .cfp_refuse,
    .tx_valid, .tx_pkt, .bcn_valid, .bcn, .bcn_slot_active, .scp_active, .cfp_active);
  relay_peer peer (.core_clk, .rst, .ack_en, .ack_delay(4'h3), .send, .send_pkt, .tx_valid, .tx_pkt,
    .rx_valid, .rx_pkt);

  initial forever #4 core_clk = ~core_clk;

  // the whole run needs about 1500 cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 6000) begin
      errors++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic test_done;
    if (errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic do_rst;
    @(posedge core_clk) rst <= 1'b1;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
  endtask : do_rst

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge core_clk);
    addr    <= a;
    wr_data <= v;
    wr_en   <= 1'b1;
    @(posedge core_clk) wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge core_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge core_clk) rd_en <= 1'b0;
    @(negedge core_clk) d = rd_data;
  endtask : rd

  task automatic inject(input pkt_type p);
    @(posedge core_clk);
    send     <= 1'b1;
    send_pkt <= p;
    @(posedge core_clk) send <= 1'b0;
  endtask : inject

  task automatic wtx(output pkt_type p);
    int k;
    k = 0;
    do begin
      @(negedge core_clk);
      k++;
    end while (tx_valid !== 1'b1 && k < 20);
    p = tx_pkt;
  endtask : wtx

  // counts the indication levels over the frame it waits through
  task automatic wbcn(output beacon_type b, output int k);
    k  = 0;
    bs = 0;
    ss = 0;
    cs = 0;
    do begin
      @(negedge core_clk);
      k++;
      bs += int'(bcn_slot_active);
      ss += int'(scp_active);
      cs += int'(cfp_active);
    end while (bcn_valid !== 1'b1 && k < 200);
    b = bcn;
  endtask : wbcn

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_frame;
    beacon_type       a, b;
    logic [SEQ_W-1:0] s;
    int               k, i;
    wbcn(a, k);
    for (i = 0; i < 33; i++) begin
      wbcn(b, k);
      s = a.sequence_no + 5'h01;
      chk("beacon period", 32, k);
      chk("sequence", s, b.sequence_no);
      a = b;
    end
    chk("slot level", 4, bs);
    chk("shared level", 28, ss);
    chk("slot count", 1, b.slot_count);
    chk("shared length", 28, b.scp_len);
    chk("robust power", 3, {b.robust_mode, b.max_power});
    chk("own slot", 0, b.slot_index);
  endtask : t_frame

  task automatic contention_free_period(input logic [CNT_W-1:0] len, input logic g);
    @(posedge core_clk);
    cfp_req     <= 1'b1;
    cfp_req_len <= len;
    @(posedge core_clk) cfp_req <= 1'b0;
    @(negedge core_clk);
    chk("grant", g, cfp_grant);
    chk("refuse", !g, cfp_refuse);
  endtask : contention_free_period

  task automatic t_cfp;
    beacon_type b;
    int         k;
    contention_free_period(16'h0018, 1'b0);
    contention_free_period(16'h0010, 1'b1);
    wbcn(b, k);
    wbcn(b, k);
    chk("free length", 16'h0010, b.cfp_len);
    chk("shared length", 16'h000C, b.scp_len);
    chk("free level", 16, cs);
    chk("shared level", 12, ss);
  endtask : t_cfp

  task automatic t_promo;
    beacon_type       b;
    pkt_type          p;
    logic [SEQ_W-1:0] tg;
    int               k, i;
    wbcn(b, k);
    tg     = b.sequence_no + 5'h02;
    p      = '0;
    p.kind = PKT_PROMO_ACK;
    inject(p);
    wtx(p);
    chk("assign kind", PKT_SLOT_ASG, p.kind);
    chk("assign slot", 1, p.slot_index);
    chk("assign freq", 2, p.frequency);
    chk("assign count", 2, p.slot_count);
    chk("assign target", tg, p.target_seq);
    wtx(p);
    chk("change kind", PKT_FRM_CHG, p.kind);
    repeat (8) @(negedge core_clk);
    rd(STATUS_OFS);
    chk("ack seen", 1, d[16]);
    for (i = 0; i < 3; i++) begin
      wbcn(b, k);
      k = (b.sequence_no == tg - 5'h01) ? 1 : 2;
      chk("slots", k, b.slot_count);
      chk("shared length", 32 - 4 * k - 16, b.scp_len);
    end
    tg = b.sequence_no + 5'h02;
    wr(SLOT_PLAN_OFS, {19'h0, tg, 8'h01});
    for (i = 0; i < 3; i++) begin
      wbcn(b, k);
      chk("slots kept", 2, b.slot_count);
    end
  endtask : t_promo

  task automatic t_relay;
    pkt_type    p, q;
    beacon_type b;
    int         k;
    ack_en <= 1'b0;
    do_rst();
    wr(FRAME_LEN_OFS, 32'h00000020);
    wr(CTRL_OFS, 32'h00000002);
    p            = '0;
    p.kind       = PKT_SLOT_ASG;
    p.dest_below = 1'b1;
    p.slot_index = 3'h3;
    p.frequency  = 4'h4;
    p.target_seq = 5'h07;
    p.slot_count = 3'h4;
    inject(p);
    wtx(q);
    chk("forward", p, q);
    p.kind       = PKT_FRM_CHG;
    p.dest_below = 1'b0;
    inject(p);
    wtx(q);
    chk("rebroadcast", p, q);
    // a heard beacon sets the structure; the relay keeps it in silent frames
    @(posedge core_clk);
    rx_bcn_valid       <= 1'b1;
    rx_bcn.sequence_no <= 5'h10;
    rx_bcn.slot_count  <= 3'h2;
    @(posedge core_clk) rx_bcn_valid <= 1'b0;
    p            = '0;
    p.kind       = PKT_SLOT_ASG;
    p.for_me     = 1'b1;
    p.slot_index = 3'h1;
    p.frequency  = 4'h2;
    p.target_seq = 5'h11;
    inject(p);
    wtx(q);
    chk("ack kind", PKT_SLOT_ACK, q.kind);
    wbcn(b, k);
    chk("relay slot", 1, b.slot_index);
    chk("relay apply", 5'h11, b.sequence_no);
    chk("kept count", 2, b.slot_count);
    wbcn(b, k);
    chk("relay period", 64, k);
  endtask : t_relay

  initial begin
    do_rst();
    rd(FRAME_LEN_OFS);
    chk("frame length", 32'h00000114, d);
    rd(MIN_SCP_OFS);
    chk("min shared", 32'h00000040, d);
    rd(3'h7);
    chk("unmapped", 0, d);
    wr(FRAME_LEN_OFS, 32'h00000020);
    wr(MIN_SCP_OFS, 32'h00000008);
    wr(CTRL_OFS, 32'h00000003);
    ack_en <= 1'b1;
    t_frame();
    t_cfp();
    t_promo();
    t_relay();
    test_done();
  end
endmodule : beacon_sched_bench
